// ==== design/eeprom_port_pkg.sv ====
// Constants and types shared by the dual mode identification EEPROM port
`default_nettype none
package eeprom_port_pkg;
	// System clock rate
	localparam int CLK_MHZ = 125;
	// Bus input glitch suppression, longest ignored pulse
	localparam int FILTER_NS = 100;
	localparam int FILTER_CYC = (FILTER_NS * CLK_MHZ) / 1000;
	// Self-timed program cycle, longest time
	localparam int WRITE_MS = 5;
	localparam int WRITE_CYC = WRITE_MS * CLK_MHZ * 1000;
	// Start addresses chosen during initialisation
	localparam logic [6:0] ADDR_TOP = 7'h7F;
	localparam logic [6:0] ADDR_BOTTOM = 7'h00;
	// Fixed upper nibble of the slave address
	localparam logic [3:0] DEV_CODE = 4'hA;
	// Bit slot indices: last data bit and the ninth slot
	localparam logic [3:0] LAST_BIT = 4'h7;
	localparam logic [3:0] NINTH_SLOT = 4'h8;
	// Write FIFO shape: address and data per entry
	localparam int FIFO_W = 15;
	localparam int FIFO_D = 4;
	// Two-wire bus states, Gray along the write path
	typedef enum logic [2:0] {
		BUS_IDLE = 3'h0,
		BUS_DEV  = 3'h1,
		BUS_WADR = 3'h3,
		BUS_WDAT = 3'h2,
		BUS_RDAT = 3'h6
	} bus_state_type;
endpackage : eeprom_port_pkg
`default_nettype wire

// ==== design/dual_mode_display_id_eeprom_port.sv ====
// Dual mode identification EEPROM front end with filter and write FIFO
`timescale 1ns/10ps
`default_nettype none

// Synchroniser and glitch filter for one bus pin
module glitch_filter #(
	parameter int CYC = 12
) (
	// Clock and reset
	input  wire logic sys_clk_i,
	input  wire logic nrst_i,
	// Raw pin and filtered level
	input  wire logic pin_i,
	output logic      level_o
);
	typedef struct packed {
		logic       s1;     // First sync stage
		logic       s2;     // Second sync stage
		logic       level;  // Accepted level
		logic [7:0] cnt;    // Cycles the pin has disagreed
	} filt_type;
	filt_type st, next_st;

	// Accept a new level only after CYC steady cycles
	always_comb begin
		next_st = st;
		next_st.s1 = pin_i;
		next_st.s2 = st.s1;
		if (st.s2 == st.level) begin
			next_st.cnt = 8'h00;
		end else if (st.cnt == 8'(CYC - 1)) begin
			next_st.level = st.s2;
			next_st.cnt = 8'h00;
		end else begin
			next_st.cnt = st.cnt + 8'h01;
		end
	end

	// Idle bus reads high
	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			st <= '{s1: 1'b1, s2: 1'b1, level: 1'b1, cnt: 8'h00};
		end else begin
			st <= next_st;
		end
	end

	assign level_o = st.level;

	a_filter_steady: assert property (
		@(posedge sys_clk_i) disable iff (!nrst_i)
		$changed(st.level) |-> $past(st.cnt) == 8'(CYC - 1))
		else $error("filtered level moved before the suppression time");
endmodule : glitch_filter

// Small FIFO of write entries
module write_fifo #(
	parameter int W = 15,
	parameter int D = 4
) (
	// Clock and reset
	input  wire logic         sys_clk_i,
	input  wire logic         nrst_i,
	// Fill side
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	// Drain side
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic [W-1:0]      out_data_o
);
	localparam int AW = $clog2(D);
	typedef struct packed {
		logic [D-1:0][W-1:0] mem; // Entry storage
		logic [AW-1:0]       wr;  // Write index
		logic [AW-1:0]       rd;  // Read index
		logic [AW:0]         cnt; // Entries held
	} fifo_type;
	fifo_type st, next_st;
	logic push;
	logic pop;

	// Pointer and count update
	always_comb begin
		next_st = st;
		push = in_valid_i && in_ready_o;
		pop = out_valid_o && out_ready_i;
		if (push) begin
			next_st.mem[st.wr] = in_data_i;
			next_st.wr = st.wr + AW'(1);
		end
		if (pop) begin
			next_st.rd = st.rd + AW'(1);
		end
		next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign in_ready_o = st.cnt != (AW+1)'(D);
	assign out_valid_o = st.cnt != '0;
	assign out_data_o = st.mem[st.rd];
endmodule : write_fifo

module dual_mode_display_id_eeprom_port #(
	parameter int WRITE_CYCLES = eeprom_port_pkg::WRITE_CYC
) (
	// Clock and power-up reset
	input  wire logic sys_clk_i,
	input  wire logic nrst_i,
	// Link pins
	input  wire logic transmit_only_clock_i,
	input  wire logic bus_clock_i,
	input  wire logic bus_data_i,
	output logic      bus_data_o,
	output logic      bus_data_oe_o,
	// Status
	output logic      bidir_mode_o,
	output logic      program_busy_o
);
	typedef struct packed {
		logic                          transmit_only_clock_s1;    // Transmit clock sync 1
		logic                          transmit_only_clock_s2;    // Transmit clock sync 2
		logic                          transmit_only_clock_d;     // Previous synced level
		logic                          scl_d;      // Previous filtered clock
		logic                          sda_d;      // Previous filtered data
		logic                          bidir;      // Mode latch
		logic [3:0]                    init_cnt;   // Initialisation clocks seen
		logic                          init_done;  // Stream may start
		logic                          start_high; // Data level during init
		logic [3:0]                    tx_bit;     // Stream bit slot
		logic [7:0]                    tx_byte;    // Stream shifter
		logic [6:0]                    addr;       // Shared address counter
		logic [127:0][7:0]             mem;        // Array contents
		eeprom_port_pkg::bus_state_type state;     // Bus state
		logic [3:0]                    bit_cnt;    // Bus bit slot
		logic [7:0]                    rx;         // Receive shifter
		logic [7:0]                    sh;         // Read shifter
		logic                          oe;         // Pull data low
		logic                          pend;       // Write data waiting
		logic                          prog;       // Program cycle running
		logic [19:0]                   prog_cnt;   // Program cycle timer
	} port_type;
	port_type st, next_st;

	logic scl;         // Filtered bus clock
	logic sda;         // Filtered data
	logic push;        // Write entry accepted
	logic fifo_ready;  // FIFO has room
	logic fifo_valid;  // FIFO holds an entry
	logic pop;         // Entry committed to the array
	logic [14:0] fifo_q;
	logic vr, vf, sr, sf, start_c, stop_c;

	// Both bus pins go through the same filter
	glitch_filter #(.CYC(eeprom_port_pkg::FILTER_CYC)) u_scl_filt (
		.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .pin_i(bus_clock_i), .level_o(scl));
	glitch_filter #(.CYC(eeprom_port_pkg::FILTER_CYC)) u_sda_filt (
		.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .pin_i(bus_data_i), .level_o(sda));

	// Written bytes wait here until the program cycle commits them
	write_fifo #(.W(eeprom_port_pkg::FIFO_W), .D(eeprom_port_pkg::FIFO_D)) u_fifo (
		.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
		.in_valid_i(push), .in_ready_o(fifo_ready), .in_data_i({st.addr, st.rx}),
		.out_valid_o(fifo_valid), .out_ready_i(pop), .out_data_o(fifo_q));

	// Edge and condition detection on synced or filtered levels
	assign vr = st.transmit_only_clock_s2 && !st.transmit_only_clock_d;
	assign vf = !st.transmit_only_clock_s2 && st.transmit_only_clock_d;
	assign sr = scl && !st.scl_d;
	assign sf = !scl && st.scl_d;
	assign start_c = scl && st.scl_d && st.sda_d && !sda;
	assign stop_c = scl && st.scl_d && !st.sda_d && sda;
	assign pop = fifo_valid && st.prog;

	// Whole port: stream mode, bus mode and program cycle
	always_comb begin
		next_st = st;
		push = 1'b0;
		next_st.transmit_only_clock_s1 = transmit_only_clock_i;
		next_st.transmit_only_clock_s2 = st.transmit_only_clock_s1;
		next_st.transmit_only_clock_d = st.transmit_only_clock_s2;
		next_st.scl_d = scl;
		next_st.sda_d = sda;
		// Program cycle drains the FIFO then times out
		if (pop) begin
			next_st.mem[fifo_q[14:8]] = fifo_q[7:0];
		end
		if (st.prog) begin
			next_st.prog_cnt = st.prog_cnt + 20'h00001;
			if (st.prog_cnt == 20'(WRITE_CYCLES - 1)) begin
				next_st.prog = 1'b0;
			end
		end
		if (!st.bidir) begin
			if (sf) begin
				// Any bus clock fall leaves stream mode for good
				next_st.bidir = 1'b1;
				next_st.oe = 1'b0;
				next_st.state = eeprom_port_pkg::BUS_IDLE;
			end else if (vr && !st.init_done) begin
				// Init clocks: keep sampling the data level
				next_st.init_cnt = st.init_cnt + 4'h1;
				if (st.init_cnt < eeprom_port_pkg::NINTH_SLOT) begin
					next_st.start_high = sda;
				end else begin
					next_st.init_done = 1'b1;
					next_st.tx_bit = eeprom_port_pkg::NINTH_SLOT;
					next_st.addr = st.start_high ? eeprom_port_pkg::ADDR_TOP
						: eeprom_port_pkg::ADDR_BOTTOM;
				end
			end else if (vf && st.init_done) begin
				// Data moves on the falling edge, host samples on rising
				if (st.tx_bit == eeprom_port_pkg::NINTH_SLOT) begin
					next_st.tx_byte = st.mem[st.addr];
					next_st.oe = !st.mem[st.addr][7];
					next_st.tx_bit = 4'h0;
					next_st.addr = st.addr + 7'h01;
				end else if (st.tx_bit == eeprom_port_pkg::LAST_BIT) begin
					next_st.oe = 1'b0;
					next_st.tx_bit = eeprom_port_pkg::NINTH_SLOT;
				end else begin
					next_st.tx_byte = {st.tx_byte[6:0], 1'b0};
					next_st.oe = !st.tx_byte[6];
					next_st.tx_bit = st.tx_bit + 4'h1;
				end
			end
		end else if (stop_c) begin
			// Stop ends the frame and, if write data is waiting, launches programming
			next_st.state = eeprom_port_pkg::BUS_IDLE;
			next_st.oe = 1'b0;
			if (st.pend) begin
				next_st.prog = 1'b1;
				next_st.prog_cnt = 20'h00000;
				next_st.pend = 1'b0;
			end
		end else if (start_c) begin
			// While programming the interface stays deaf
			next_st.state = st.prog ? eeprom_port_pkg::BUS_IDLE
				: eeprom_port_pkg::BUS_DEV;
			// The clock fall after a start wraps to slot 0, as after an ack
			next_st.bit_cnt = eeprom_port_pkg::NINTH_SLOT;
			next_st.oe = 1'b0;
		end else if (sr && st.state != eeprom_port_pkg::BUS_IDLE) begin
			// Sample on the rising bus clock
			if (st.bit_cnt < eeprom_port_pkg::NINTH_SLOT) begin
				next_st.rx = {st.rx[6:0], sda};
			end else if (st.state == eeprom_port_pkg::BUS_RDAT && sda) begin
				next_st.state = eeprom_port_pkg::BUS_IDLE; // No master ack
			end
		end else if (sf && st.state != eeprom_port_pkg::BUS_IDLE) begin
			// Drive on the falling bus clock
			next_st.bit_cnt = (st.bit_cnt == eeprom_port_pkg::NINTH_SLOT) ? 4'h0
				: st.bit_cnt + 4'h1;
			next_st.oe = 1'b0;
			if (st.bit_cnt == eeprom_port_pkg::LAST_BIT) begin
				unique case (st.state)
					eeprom_port_pkg::BUS_DEV: begin
						if (st.rx[7:4] == eeprom_port_pkg::DEV_CODE) begin
							next_st.oe = 1'b1;
							next_st.state = st.rx[0] ? eeprom_port_pkg::BUS_RDAT
								: eeprom_port_pkg::BUS_WADR;
						end else begin
							next_st.state = eeprom_port_pkg::BUS_IDLE;
						end
					end
					eeprom_port_pkg::BUS_WADR: begin
						next_st.addr = st.rx[6:0];
						next_st.oe = 1'b1;
						next_st.state = eeprom_port_pkg::BUS_WDAT;
					end
					eeprom_port_pkg::BUS_WDAT: begin
						// Low transmit clock or a full FIFO: no ack
						if (st.transmit_only_clock_s2 && fifo_ready) begin
							push = 1'b1;
							next_st.oe = 1'b1;
							next_st.pend = 1'b1;
							next_st.addr = {st.addr[6:4], st.addr[3:0] + 4'h1};
						end else begin
							next_st.state = eeprom_port_pkg::BUS_IDLE;
						end
					end
					eeprom_port_pkg::BUS_RDAT: begin
						next_st.oe = 1'b0; // Master acks here
					end
					default: begin
						next_st.state = eeprom_port_pkg::BUS_IDLE;
					end
				endcase
			end else if (st.state == eeprom_port_pkg::BUS_RDAT) begin
				if (st.bit_cnt == eeprom_port_pkg::NINTH_SLOT) begin
					next_st.sh = st.mem[st.addr];
					next_st.oe = !st.mem[st.addr][7];
					next_st.addr = st.addr + 7'h01;
				end else begin
					next_st.sh = {st.sh[6:0], 1'b0};
					next_st.oe = !st.sh[6];
				end
			end
		end
	end

	// Power-up reset clears everything but the pin history, including the array
	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			st <= '0;
			// Pin history starts at the idle high level, so no false edge follows reset
			{st.transmit_only_clock_s1, st.transmit_only_clock_s2, st.transmit_only_clock_d, st.scl_d, st.sda_d} <= 5'h1F;
		end else begin
			st <= next_st;
		end
	end

	// Open drain: the pad value is always low
	assign bus_data_o = 1'b0;
	assign bus_data_oe_o = st.oe;
	assign bidir_mode_o = st.bidir;
	assign program_busy_o = st.prog;

	a_pad_never_high: assert property (
		@(posedge sys_clk_i) disable iff (!nrst_i) bus_data_o == 1'b0)
		else $error("data pad driven high");
	a_mode_switch_fall: assert property (
		@(posedge sys_clk_i) disable iff (!nrst_i) !st.bidir && sf |=> st.bidir)
		else $error("bus clock fall did not switch mode");
	a_mode_stays_bidir: assert property (
		@(posedge sys_clk_i) disable iff (!nrst_i) st.bidir |=> st.bidir)
		else $error("left bidirectional mode");
	a_init_line_free: assert property (
		@(posedge sys_clk_i) disable iff (!nrst_i) !st.bidir && !st.init_done |-> !st.oe)
		else $error("data driven during initialisation");
	a_start_addr_pick: assert property (
		@(posedge sys_clk_i) disable iff (!nrst_i)
		!st.bidir && !sf && vr && !st.init_done && st.init_cnt == 4'h8
		|=> st.addr == ($past(st.start_high) ? 7'h7F : 7'h00))
		else $error("wrong start address");
	a_ninth_slot_free: assert property (
		@(posedge sys_clk_i) disable iff (!nrst_i)
		!st.bidir && st.tx_bit == 4'h8 |-> !st.oe)
		else $error("ninth bit not released");
	a_addr_wraps: assert property (
		@(posedge sys_clk_i) disable iff (!nrst_i)
		!st.bidir && !sf && vf && st.init_done && st.tx_bit == 4'h8 && st.addr == 7'h7F
		|=> st.addr == 7'h00)
		else $error("address did not wrap");
	a_write_needs_transmit_only_clock: assert property (
		@(posedge sys_clk_i) disable iff (!nrst_i) push |-> st.transmit_only_clock_s2 ##1 st.pend)
		else $error("write taken with transmit clock low");
	a_busy_no_ack: assert property (
		@(posedge sys_clk_i) disable iff (!nrst_i)
		st.prog |-> st.state == eeprom_port_pkg::BUS_IDLE && !st.oe)
		else $error("interface active while programming");
	a_prog_bounded: assert property (
		@(posedge sys_clk_i) disable iff (!nrst_i)
		st.prog |-> st.prog_cnt < 20'(WRITE_CYCLES))
		else $error("program cycle overran");
endmodule : dual_mode_display_id_eeprom_port
`default_nettype wire

// ==== tb/host_master.sv ====
// Behavioural two-wire host that also sources the transmit clock
`timescale 1ns/10ps
`default_nettype none
module host_master #(
	parameter int H         = 40,
	parameter int PWRUP_CYC = 1000
) (
	// Clock and resolved data wire
	input  wire logic sys_clk_i,
	input  wire logic sda_i,
	// Driven link pins
	output logic      scl_o,
	output logic      sda_o,
	output logic      transmit_only_clock_o
);
	// Pins idle high from time zero
	initial begin
		scl_o  = 1'b1;
		sda_o  = 1'b1;
		transmit_only_clock_o = 1'b1;
	end
	// Wait whole system cycles
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk_i);
	endtask : cyc
	// Set both bus pins after an edge, then hold them
	task automatic drv(input logic c, input logic d, input int n);
		@(posedge sys_clk_i);
		scl_o <= c;
		sda_o <= d;
		cyc(n);
	endtask : drv
	// Start condition; clock dropped first so a repeated start is clean
	task automatic start();
		drv(1'b0, 1'b1, H);
		drv(1'b1, 1'b1, H);
		drv(1'b1, 1'b0, H);
		drv(1'b0, 1'b0, H);
	endtask : start
	// Stop condition
	task automatic stop();
		drv(1'b0, 1'b0, H);
		drv(1'b1, 1'b0, H);
		drv(1'b1, 1'b1, H);
	endtask : stop
	// One bit slot, wire sampled in mid clock high
	task automatic bit_slot(input logic b, output logic r);
		drv(1'b0, b, H);
		drv(1'b1, b, H / 2);
		r = sda_i;
		cyc(H / 2);
	endtask : bit_slot
	// Byte out, acknowledge back
	task automatic send(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_slot(d[i], r);
		end
		bit_slot(1'b1, r);
		ack = ~r;
	endtask : send
	// Byte in, then acknowledge or not
	task automatic recv(input logic ack_in, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_slot(1'b1, r);
			d[i] = r;
		end
		bit_slot(~ack_in, r);
	endtask : recv
	// One clock fall on purpose moves the device to bus mode
	task automatic mode_switch();
		drv(1'b0, 1'b1, H);
		drv(1'b1, 1'b1, H);
	endtask : mode_switch
	// Low pulse of 64 ns, under the suppression time
	task automatic glitch();
		drv(1'b0, 1'b1, 7);
		drv(1'b1, 1'b1, H);
	endtask : glitch
	// One 64 ns transmit clock pulse, low half first
	task automatic vpulse();
		@(posedge sys_clk_i);
		transmit_only_clock_o <= 1'b0;
		cyc(3);
		@(posedge sys_clk_i);
		transmit_only_clock_o <= 1'b1;
		cyc(3);
	endtask : vpulse
	// Transmit clock level; high allows programming
	task automatic vset(input logic v);
		@(posedge sys_clk_i);
		transmit_only_clock_o <= v;
	endtask : vset
	// Data level offered during initialisation
	task automatic pin_sda(input logic d);
		@(posedge sys_clk_i);
		sda_o <= d;
	endtask : pin_sda
	// Settling time after power-up, shortened for the run
	task automatic power_wait();
		cyc(PWRUP_CYC);
	endtask : power_wait
endmodule : host_master
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the dual mode identification EEPROM port
`timescale 1ns/10ps
`default_nettype none
module tb;
	// Shortened program cycle keeps the run brief
	localparam int WCYC = 2000;
	logic       sys_clk_i; // System clock
	logic       nrst_i;    // Power-up reset, low active
	logic       scl;       // Host pins
	logic       sda_h;
	logic       transmit_only_clock;
	wire        sda_w;     // Wire with pull-up
	logic       oe;        // Device outputs
	logic       dout;
	logic       bidir;
	logic       busy;
	int         n_fail;
	int         checked;
	integer     seed;
	logic [7:0] mem [128]; // Expected memory image
	// Open-drain wire resolution
	assign sda_w = (oe ? dout : 1'b1) & sda_h;
	dual_mode_display_id_eeprom_port #(.WRITE_CYCLES(WCYC)) dut_u (
		.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .transmit_only_clock_i(transmit_only_clock),
		.bus_clock_i(scl), .bus_data_i(sda_w), .bus_data_o(dout),
		.bus_data_oe_o(oe), .bidir_mode_o(bidir), .program_busy_o(busy));
	host_master #(.H(40), .PWRUP_CYC(1000)) host_u (
		.sys_clk_i(sys_clk_i), .sda_i(sda_w), .scl_o(scl), .sda_o(sda_h),
		.transmit_only_clock_o(transmit_only_clock));
	// 125 MHz clock
	initial begin
		sys_clk_i = 1'b0;
		forever #4 sys_clk_i = ~sys_clk_i;
	end
	// Compare and count
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// Verdict and end of run
	task automatic final_report();
		if (n_fail == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : final_report
	// Enable expected in a stream slot: bit zero pulls the wire low
	function automatic logic exp_oe(input logic [7:0] b, input int s);
		return (s < 8) ? ~b[7 - s] : 1'b0;
	endfunction : exp_oe
	// Power-up: memory image cleared, pins high, then init level
	task automatic power_up(input logic lvl);
		host_u.pin_sda(1'b1);
		nrst_i <= 1'b0;
		repeat (3) @(posedge sys_clk_i);
		nrst_i <= 1'b1;
		foreach (mem[i]) mem[i] = 8'h00;
		host_u.cyc(16);
		host_u.pin_sda(lvl);
	endtask : power_up
	// Initialisation then nb streamed bytes
	task automatic stream(input logic lvl, input int nb);
		logic [6:0] a;
		a = lvl ? 7'h7F : 7'h00;
		repeat (9) begin
			host_u.vpulse();
			#1;
			chk(oe, 1'b0);
		end
		repeat (nb) begin
			for (int s = 0; s < 9; s++) begin
				host_u.vpulse();
				#1;
				chk(oe, exp_oe(mem[a], s));
				chk({dout, bidir}, 2'b00);
			end
			a = a + 7'h01;
		end
	endtask : stream
	// Start and slave byte with random ignored bits
	task automatic sel(input logic rw, input logic [3:0] code, output logic ack);
		host_u.start();
		host_u.send({code, 3'($random(seed)), rw}, ack);
	endtask : sel
	// Write nb random bytes; only four fit the buffer
	task automatic wr(input logic [6:0] a, input int nb, input logic en);
		logic       ack;
		logic [7:0] d;
		host_u.vset(en);
		sel(1'b0, eeprom_port_pkg::DEV_CODE, ack);
		chk(ack, 1'b1);
		host_u.send({1'b0, a}, ack);
		chk(ack, 1'b1);
		for (int i = 0; i < nb; i++) begin
			d = 8'($random(seed));
			host_u.send(d, ack);
			chk(ack, en && i < 4);
			if (en && i < 4) begin
				mem[{a[6:4], a[3:0] + 4'(i)}] = d;
			end
		end
		host_u.stop();
	endtask : wr
	// Bounded wait for the program cycle to end
	task automatic idle_wait();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < WCYC) begin
			@(posedge sys_clk_i);
			n++;
		end
		chk(busy, 1'b0);
		if (n == WCYC) begin
			final_report();
		end
	endtask : idle_wait
	// Program cycle running: polls refused, clock may drop
	task automatic prog_wait();
		logic ack;
		chk(busy, 1'b1);
		host_u.vset(1'b0);
		sel(1'b0, eeprom_port_pkg::DEV_CODE, ack);
		chk(ack, 1'b0);
		host_u.stop();
		idle_wait();
	endtask : prog_wait
	// Selective read of nb sequential bytes
	task automatic rd(input logic [6:0] a, input int nb);
		logic       ack;
		logic [7:0] d;
		sel(1'b0, eeprom_port_pkg::DEV_CODE, ack);
		host_u.send({1'b0, a}, ack);
		sel(1'b1, eeprom_port_pkg::DEV_CODE, ack);
		chk(ack, 1'b1);
		for (int i = 0; i < nb; i++) begin
			host_u.recv(i < nb - 1, d);
			chk(d, mem[7'(a + 7'(i))]);
		end
		host_u.stop();
	endtask : rd
	// Main sequence
	initial begin
		logic [6:0] a;
		logic [3:0] code;
		logic       ack;
		seed = 41;
		n_fail = 0;
		checked = 0;
		nrst_i = 1'b0;
		power_up(1'b1);
		host_u.glitch();
		chk(bidir, 1'b0);
		stream(1'b1, 130);
		power_up(1'b0);
		stream(1'b0, 2);
		host_u.mode_switch();
		chk(bidir, 1'b1);
		repeat (20) host_u.vpulse();
		chk({bidir, oe}, 2'b10);
		host_u.power_wait();
		a = 7'($random(seed));
		wr(a, 5, 1'b1);
		prog_wait();
		for (int i = 0; i < 4; i++) begin
			rd({a[6:4], a[3:0] + 4'(i)}, 1);
		end
		wr(7'h7F, 1, 1'b1);
		prog_wait();
		wr(7'h00, 1, 1'b1);
		prog_wait();
		rd(7'h7F, 2);
		wr(a, 1, 1'b0);
		idle_wait();
		rd(a, 1);
		repeat (3) begin
			code = 4'($random(seed));
			code = (code == eeprom_port_pkg::DEV_CODE) ? 4'hB : code;
			sel(1'b0, code, ack);
			chk(ack, 1'b0);
			host_u.stop();
		end
		final_report();
	end
endmodule : tb
`default_nettype wire
